/* dv/adc_pair_model.sv */
// model of the two converter channels feeding the downconverter
`timescale 1ns/1ps
module adc_pair_model #(
    parameter int SAMPLE_W = 16
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic slow_in,
    output logic sample_valid_out,
    output logic signed [SAMPLE_W-1:0] chan_a_out,
    output logic signed [SAMPLE_W-1:0] chan_b_out
);
    logic [1:0] pace_r;
    // even spacing only: a per-clock accumulator would then not flip sign
    always_ff @(posedge clk_in) begin
        if (rst_in || pace_r == (slow_in ? 2'h3 : 2'h1)) begin
            pace_r <= 2'h0;
        end else begin
            pace_r <= pace_r + 2'h1;
        end
    end
    assign sample_valid_out = !rst_in && pace_r == 2'h0;
    // channel a silent, channel b a steady positive level
    assign chan_a_out = '0;
    assign chan_b_out = SAMPLE_W'(16'h4000);
endmodule : adc_pair_model

/* dv/tb.sv */
// self-checking bench of the downconverter channel configuration
`timescale 1ns/1ps
module tb;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, slow = 1'b0;
    logic [13:0] adr = 14'h0000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_w = 32'h0, rd_dat, q;
    logic ack, smp_v, o_v, q_v;
    logic signed [15:0] ch_a, ch_b, i_o, q_o, i_s, q_s, i_p;
    logic q_vs;
    logic [3:0] stg;
    logic [4:0] rate;
    int failures = 0;
    int tests_run = 0;
    int dc_sum;
    logic [11:0] regs [12] = '{12'h330, 12'h331, 12'h334, 12'h335, 12'h336, 12'h337, 12'h338, 12'h33A,
        12'h33D, 12'h33E, 12'h340, 12'h342};
    // rows, one nibble each: complex-to-real, code, stages, log2 of overall rate
    logic [15:0] rows [8] = '{16'h0311, 16'h0032, 16'h0173, 16'h02F4, 16'h1310, 16'h1031, 16'h1172, 16'h12F3};
    always #10 clk_in = ~clk_in;
    adc_pair_model #(.SAMPLE_W(16)) adc_pair_model_i (.clk_in(clk_in), .rst_in(rst_in), .slow_in(slow),
        .sample_valid_out(smp_v), .chan_a_out(ch_a), .chan_b_out(ch_b));
    ddc_channel #(.SAMPLE_W(16)) ddc_channel_i (.clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat_w),
        .wb_dat_out(rd_dat), .wb_ack_out(ack), .sample_valid_in(smp_v), .chan_a_in(ch_a), .chan_b_in(ch_b),
        .out_valid_out(o_v), .i_out(i_o), .q_out(q_o), .q_valid_out(q_v), .stage_enable_out(stg),
        .decim_rate_out(rate));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (failures == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    // one classic cycle; ack and read data taken at the same edge
    task automatic wb(input logic [11:0] idx, input logic w, input logic [3:0] s, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'h0};
        sel <= s;
        dat_w <= {24'h0, d};
        do begin
            @(posedge clk_in);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rd_dat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            failures++;
            give_verdict();
        end
    endtask : wb
    task automatic next_out();
        int n;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (o_v !== 1'b1 && n < 20);
        i_s = i_o;
        q_s = q_o;
        q_vs = q_v;
        if (o_v !== 1'b1) begin
            failures++;
            give_verdict();
        end
    endtask : next_out
    task automatic do_reset(input int n);
        rst_in <= 1'b1;
        repeat (n) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
    endtask : do_reset
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        @(posedge clk_in);
        check(stg, 4'h3);
        check(rate, 5'h04);
        foreach (regs[k]) begin
            wb(regs[k], 1'b0, 4'hF, 8'h00);
            check(q, k == 1 ? 32'h05 : 32'h00);
        end
        foreach (rows[k]) begin
            wb(12'h330, 1'b1, 4'h1, {4'h0, rows[k][12], 1'b0, rows[k][9:8]});
            next_out();
            next_out();
            check(stg, rows[k][7:4]);
            check(rate, 5'h01 << rows[k][3:0]);
            check(q_vs, !rows[k][12]);
            if (rows[k][12]) check(q_s, 16'h0000);
        end
        // byte lanes: each of the six step bytes and four of the six offset bytes holds its own value
        foreach (regs[k]) if (k > 1) wb(regs[k], 1'b1, 4'h1, 8'hA0 + 8'(k));
        foreach (regs[k]) if (k > 1) begin
            wb(regs[k], 1'b0, 4'hF, 8'h00);
            check(q, 32'hA0 + k);
            wb(regs[k], 1'b1, 4'h1, 8'h00);
        end
        // reserved bits, unmapped place, disabled byte lane
        wb(12'h330, 1'b1, 4'h1, 8'hFF);
        wb(12'h330, 1'b0, 4'hF, 8'h00);
        check(q, 32'h0B);
        wb(12'h331, 1'b1, 4'h1, 8'hFF);
        wb(12'h331, 1'b0, 4'hF, 8'h00);
        check(q, 32'h05);
        wb(12'h333, 1'b1, 4'h1, 8'hFF);
        wb(12'h333, 1'b0, 4'hF, 8'h00);
        check(q, 32'h00);
        wb(12'h334, 1'b1, 4'h2, 8'h5A);
        wb(12'h334, 1'b0, 4'hF, 8'h00);
        check(q, 32'h00);
        // byte-lane writes left the accumulator at some phase: start the mixer from zero
        do_reset(2);
        // routing: silent channel a gives zero, channel b a live path
        wb(12'h330, 1'b1, 4'h1, 8'h00);
        for (int r = 0; r < 8; r += 4) for (int s = 0; s < 2; s++) begin
            wb(12'h331, 1'b1, 4'h1, 8'(r + s));
            next_out();
            next_out();
            check(i_s != 0, s == 1);
            check(q_s != 0, r == 4);
        end
        // half-turn offset inverts the steady level
        wb(12'h331, 1'b1, 4'h1, 8'h05);
        next_out();
        next_out();
        check(i_s[15], 1'b0);
        wb(12'h342, 1'b1, 4'h1, 8'h80);
        next_out();
        next_out();
        check(i_s[15], 1'b1);
        wb(12'h342, 1'b1, 4'h1, 8'h00);
        // real mode: the quarter-rate shift moves a steady level off zero, so four outputs cancel
        wb(12'h330, 1'b1, 4'h1, 8'h08);
        next_out();
        next_out();
        dc_sum = 0;
        repeat (4) begin
            next_out();
            dc_sum += i_s;
        end
        check(dc_sum, 32'h0000_0000);
        wb(12'h330, 1'b1, 4'h1, 8'h00);
        // half-turn step flips the sign once per sample, at either pace
        wb(12'h33A, 1'b1, 4'h1, 8'h80);
        for (int p = 0; p < 2; p++) begin
            slow <= p[0];
            next_out();
            next_out();
            i_p = i_s;
            next_out();
            check(i_s[15], !i_p[15]);
        end
        // second reset in mid-run
        do_reset(2);
        wb(12'h33A, 1'b0, 4'hF, 8'h00);
        check(q, 32'h00);
        wb(12'h331, 1'b0, 4'hF, 8'h00);
        check(q, 32'h05);
        give_verdict();
    end
endmodule : tb

/* logic/ddc_channel.sv */
// downconverter channel: register file, input routing, oscillator, mixer and decimation select
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
module ddc_channel #(
    parameter int SAMPLE_W = 16
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [13:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic sample_valid_in,
    input wire logic signed [SAMPLE_W-1:0] chan_a_in,
    input wire logic signed [SAMPLE_W-1:0] chan_b_in,
    output logic out_valid_out,
    output logic signed [SAMPLE_W-1:0] i_out,
    output logic signed [SAMPLE_W-1:0] q_out,
    output logic q_valid_out,
    output logic [3:0] stage_enable_out,
    output logic [4:0] decim_rate_out
);
    initial begin
        if (SAMPLE_W < 4 || SAMPLE_W > 24) begin
            $error("SAMPLE_W out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register file
    logic [7:0] control_r;
    logic [7:0] routing_r;
    logic [7:0] step_r [ddc_cfg_pkg::STEP_BYTES];
    logic [7:0] ofs_r [ddc_cfg_pkg::STEP_BYTES];
    logic [ddc_cfg_pkg::ADDR_W-1:0] idx;
    logic wr_en;
    logic [7:0] rd_byte;
    logic hit;

    assign idx = wb_adr_in[13:2];
    assign wr_en = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_sel_in[0];

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wb_ack_out <= 1'b0;
        end else begin
            // ack one cycle after the strobe, dropped the next cycle
            wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            control_r <= ddc_cfg_pkg::CTRL_RESET;
            routing_r <= ddc_cfg_pkg::ROUTE_RESET;
        end else if (wr_en) begin
            if (idx == ddc_cfg_pkg::IDX_CONTROL) begin
                control_r <= wb_dat_in[7:0] & ddc_cfg_pkg::CTRL_RW_MASK;
            end
            if (idx == ddc_cfg_pkg::IDX_ROUTING) begin
                routing_r <= wb_dat_in[7:0] & ddc_cfg_pkg::ROUTE_RW_MASK;
            end
        end
    end

    // the increment bytes are not contiguous: the top byte skips one index
    function automatic int step_slot(input logic [ddc_cfg_pkg::ADDR_W-1:0] a);
        int s;
        s = -1;
        if (a >= ddc_cfg_pkg::IDX_STEP0 && a <= ddc_cfg_pkg::IDX_STEP4) begin
            s = int'(a - ddc_cfg_pkg::IDX_STEP0);
        end else if (a == ddc_cfg_pkg::IDX_STEP5) begin
            s = 5;
        end
        return s;
    endfunction : step_slot

    function automatic int ofs_slot(input logic [ddc_cfg_pkg::ADDR_W-1:0] a);
        int s;
        s = -1;
        if (a == ddc_cfg_pkg::IDX_OFS0) begin
            s = 0;
        end else if (a >= ddc_cfg_pkg::IDX_OFS1 && a <= ddc_cfg_pkg::IDX_OFS5) begin
            s = int'(a - ddc_cfg_pkg::IDX_OFS1) + 1;
        end
        return s;
    endfunction : ofs_slot

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int k = 0; k < ddc_cfg_pkg::STEP_BYTES; k++) begin
                step_r[k] <= 8'h00;
                ofs_r[k] <= 8'h00;
            end
        end else if (wr_en) begin
            for (int k = 0; k < ddc_cfg_pkg::STEP_BYTES; k++) begin
                if (step_slot(idx) == k) begin
                    step_r[k] <= wb_dat_in[7:0];
                end
                if (ofs_slot(idx) == k) begin
                    ofs_r[k] <= wb_dat_in[7:0];
                end
            end
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        hit = 1'b1;
        if (idx == ddc_cfg_pkg::IDX_CONTROL) begin
            rd_byte = control_r;
        end else if (idx == ddc_cfg_pkg::IDX_ROUTING) begin
            rd_byte = routing_r;
        end else if (step_slot(idx) >= 0) begin
            rd_byte = step_r[step_slot(idx)];
        end else if (ofs_slot(idx) >= 0) begin
            rd_byte = ofs_r[ofs_slot(idx)];
        end else begin
            hit = 1'b0;
        end
    end

    // unmapped addresses are acked and read zero
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wb_dat_out <= 32'h0000_0000;
        end else if (wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_we_in && hit) begin
            wb_dat_out <= {24'h00_0000, rd_byte};
        end else begin
            wb_dat_out <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // decimation selection
    logic c2r;
    logic [1:0] dec_code;
    assign c2r = control_r[ddc_cfg_pkg::CTRL_C2R_BIT];
    assign dec_code = control_r[ddc_cfg_pkg::CTRL_DEC_LSB +: 2];

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            stage_enable_out <= 4'h0;
            decim_rate_out <= 5'h00;
        end else begin
            case (dec_code)
                ddc_cfg_pkg::DEC_CODE_2: begin
                    stage_enable_out <= ddc_cfg_pkg::STAGES_1;
                    decim_rate_out <= c2r ? ddc_cfg_pkg::RATE_1 : ddc_cfg_pkg::RATE_2;
                end
                ddc_cfg_pkg::DEC_CODE_4: begin
                    stage_enable_out <= ddc_cfg_pkg::STAGES_2;
                    decim_rate_out <= c2r ? ddc_cfg_pkg::RATE_2 : ddc_cfg_pkg::RATE_4;
                end
                ddc_cfg_pkg::DEC_CODE_8: begin
                    stage_enable_out <= ddc_cfg_pkg::STAGES_3;
                    decim_rate_out <= c2r ? ddc_cfg_pkg::RATE_4 : ddc_cfg_pkg::RATE_8;
                end
                default: begin
                    stage_enable_out <= ddc_cfg_pkg::STAGES_4;
                    decim_rate_out <= c2r ? ddc_cfg_pkg::RATE_8 : ddc_cfg_pkg::RATE_16;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // oscillator and mixer
    logic [ddc_cfg_pkg::PHASE_W-1:0] step_word;
    logic [ddc_cfg_pkg::PHASE_W-1:0] ofs_word;
    logic [ddc_cfg_pkg::PHASE_W-1:0] acc_r;
    logic [ddc_cfg_pkg::PHASE_W-1:0] phase;
    logic [1:0] quarter_r;
    logic signed [SAMPLE_W-1:0] i_sel;
    logic signed [SAMPLE_W-1:0] q_sel;
    logic signed [SAMPLE_W-1:0] cos_v;
    logic signed [SAMPLE_W-1:0] sin_v;
    logic signed [2*SAMPLE_W+1:0] mi;
    logic signed [2*SAMPLE_W+1:0] mq;
    logic signed [SAMPLE_W-1:0] mi_s;
    logic signed [SAMPLE_W-1:0] mq_s;

    assign step_word = {step_r[5], step_r[4], step_r[3], step_r[2], step_r[1], step_r[0]};
    assign ofs_word = {ofs_r[5], ofs_r[4], ofs_r[3], ofs_r[2], ofs_r[1], ofs_r[0]};
    assign i_sel = routing_r[ddc_cfg_pkg::ROUTE_I_BIT] ? chan_b_in : chan_a_in;
    assign q_sel = routing_r[ddc_cfg_pkg::ROUTE_Q_BIT] ? chan_b_in : chan_a_in;
    assign phase = acc_r + ofs_word;

    // accumulator wraps at 2^48 so frequency = step * fs / 2^48
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            acc_r <= '0;
            quarter_r <= 2'h0;
        end else if (sample_valid_in) begin
            acc_r <= acc_r + step_word;
            quarter_r <= quarter_r + 2'h1;
        end
    end

    // coarse lookup: a 16-entry sine table from the phase top bits, trading spur level for area
    function automatic logic signed [SAMPLE_W-1:0] sine_lut(input logic [ddc_cfg_pkg::LUT_BITS-1:0] p);
        real full;
        full = (2.0 ** (SAMPLE_W - 1)) - 1.0;
        return SAMPLE_W'($rtoi(full * $sin(2.0 * 3.141592653589793 * real'(p) / 16.0)));
    endfunction : sine_lut

    logic signed [SAMPLE_W-1:0] sin_tab [16];
    always_comb begin
        for (int k = 0; k < 16; k++) begin
            sin_tab[k] = sine_lut(ddc_cfg_pkg::LUT_BITS'(k));
        end
    end

    always_comb begin
        sin_v = sin_tab[phase[ddc_cfg_pkg::PHASE_W-1 -: ddc_cfg_pkg::LUT_BITS]];
        cos_v = sin_tab[phase[ddc_cfg_pkg::PHASE_W-1 -: ddc_cfg_pkg::LUT_BITS] + 4'h4];
        // (i + jq) * (cos - j sin)
        mi = (2*SAMPLE_W+2)'(i_sel * cos_v) + (2*SAMPLE_W+2)'(q_sel * sin_v);
        mq = (2*SAMPLE_W+2)'(q_sel * cos_v) - (2*SAMPLE_W+2)'(i_sel * sin_v);
        mi_s = mi[2*SAMPLE_W-1 -: SAMPLE_W];
        mq_s = mq[2*SAMPLE_W-1 -: SAMPLE_W];
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            i_out <= '0;
            q_out <= '0;
            out_valid_out <= 1'b0;
            q_valid_out <= 1'b0;
        end else begin
            out_valid_out <= sample_valid_in;
            q_valid_out <= sample_valid_in && !c2r;
            if (sample_valid_in) begin
                if (c2r) begin
                    // extra fs/4 mix: real part of (mi + j mq) * j^n
                    case (quarter_r)
                        2'h0: i_out <= mi_s;
                        2'h1: i_out <= -mq_s;
                        2'h2: i_out <= -mi_s;
                        default: i_out <= mq_s;
                    endcase
                    q_out <= '0;
                end else begin
                    i_out <= mi_s;
                    q_out <= mq_s;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_route_reset: assert property (@(posedge clk_in) $fell(rst_in) |-> routing_r == 8'h05)
        else $error("routing reset not 05");
    // both paths on a silent channel a: any leak of channel b shows at the mixer output
    a_i_path_sel: assert property (@(posedge clk_in) disable iff (rst_in)
        (sample_valid_in && !routing_r[ddc_cfg_pkg::ROUTE_I_BIT] && !routing_r[ddc_cfg_pkg::ROUTE_Q_BIT]
        && chan_a_in == '0) |=> i_out == '0)
        else $error("I path from wrong channel");
    a_q_path_sel: assert property (@(posedge clk_in) disable iff (rst_in)
        (sample_valid_in && !routing_r[ddc_cfg_pkg::ROUTE_I_BIT] && !routing_r[ddc_cfg_pkg::ROUTE_Q_BIT]
        && chan_a_in == '0) |=> q_out == '0)
        else $error("Q path from wrong channel");
    a_stage_code: assert property (@(posedge clk_in) disable iff (rst_in)
        ##1 ($past(dec_code) == 2'h3 && !$past(rst_in)) |-> stage_enable_out == 4'h1)
        else $error("code 11 not stage one only");
    a_real_rate: assert property (@(posedge clk_in) disable iff (rst_in)
        (c2r && dec_code == 2'h2) ##1 $stable(control_r) |-> decim_rate_out == 5'h08)
        else $error("real code 10 not decimate 8");
    a_cplx_rate: assert property (@(posedge clk_in) disable iff (rst_in)
        (!c2r && dec_code == 2'h2) ##1 $stable(control_r) |-> decim_rate_out == 5'h10)
        else $error("complex code 10 not decimate 16");
    a_acc_step: assert property (@(posedge clk_in) disable iff (rst_in)
        sample_valid_in ##1 !$past(rst_in) |-> acc_r == $past(acc_r) + $past(step_word))
        else $error("accumulator missed step");
    a_acc_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        !sample_valid_in |=> $stable(acc_r))
        else $error("accumulator moved without sample");
    a_real_no_q: assert property (@(posedge clk_in) disable iff (rst_in)
        c2r |=> !q_valid_out)
        else $error("Q valid in real mode");
    a_step_write: assert property (@(posedge clk_in) disable iff (rst_in)
        (wr_en && idx == 12'h33A) |=> step_r[5] == $past(wb_dat_in[7:0]))
        else $error("top step byte not written");
    a_ofs_write: assert property (@(posedge clk_in) disable iff (rst_in)
        (wr_en && idx == 12'h33D) |=> ofs_r[0] == $past(wb_dat_in[7:0]))
        else $error("offset low byte not written");
    a_ofs_high: assert property (@(posedge clk_in) disable iff (rst_in)
        (wr_en && idx == 12'h342) |=> ofs_r[5] == $past(wb_dat_in[7:0]))
        else $error("offset top byte not written");
endmodule : ddc_channel

/* shared/ddc_cfg_pkg.sv */
// package: register map, field layout and reset values of the downconverter channel
package ddc_cfg_pkg;
    localparam int ADDR_W = 12;
    // register indices as printed; byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_CONTROL = 12'h330;
    localparam logic [ADDR_W-1:0] IDX_ROUTING = 12'h331;
    localparam logic [ADDR_W-1:0] IDX_STEP0 = 12'h334;
    localparam logic [ADDR_W-1:0] IDX_STEP1 = 12'h335;
    localparam logic [ADDR_W-1:0] IDX_STEP2 = 12'h336;
    localparam logic [ADDR_W-1:0] IDX_STEP3 = 12'h337;
    localparam logic [ADDR_W-1:0] IDX_STEP4 = 12'h338;
    localparam logic [ADDR_W-1:0] IDX_STEP5 = 12'h33A;
    localparam logic [ADDR_W-1:0] IDX_OFS0 = 12'h33D;
    localparam logic [ADDR_W-1:0] IDX_OFS1 = 12'h33E;
    localparam logic [ADDR_W-1:0] IDX_OFS5 = 12'h342;
    localparam int STEP_BYTES = 6;
    localparam int PHASE_W = 48;
    // control register fields
    localparam int CTRL_C2R_BIT = 3;
    localparam int CTRL_DEC_LSB = 0;
    localparam logic [7:0] CTRL_RW_MASK = 8'h0B;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // routing register fields
    localparam int ROUTE_I_BIT = 0;
    localparam int ROUTE_Q_BIT = 2;
    localparam logic [7:0] ROUTE_RW_MASK = 8'h05;
    localparam logic [7:0] ROUTE_RESET = 8'h05;
    // decimation codes
    localparam logic [1:0] DEC_CODE_2 = 2'h3;
    localparam logic [1:0] DEC_CODE_4 = 2'h0;
    localparam logic [1:0] DEC_CODE_8 = 2'h1;
    localparam logic [1:0] DEC_CODE_16 = 2'h2;
    localparam logic [3:0] STAGES_1 = 4'h1;
    localparam logic [3:0] STAGES_2 = 4'h3;
    localparam logic [3:0] STAGES_3 = 4'h7;
    localparam logic [3:0] STAGES_4 = 4'hF;
    localparam logic [4:0] RATE_1 = 5'h01;
    localparam logic [4:0] RATE_2 = 5'h02;
    localparam logic [4:0] RATE_4 = 5'h04;
    localparam logic [4:0] RATE_8 = 5'h08;
    localparam logic [4:0] RATE_16 = 5'h10;
    localparam int LUT_BITS = 4;
endpackage : ddc_cfg_pkg
